// ===== clh_pkg.sv
/*
 * Shared constants, types and helpers for both ends of the character display
 * host port: strobe timing, instruction fields, start-up codes, RAM sizes.
 * Assumes a single 50 MHz system clock on both ends.
 */
package clh_pkg;
    localparam int CLK_MHZ      = 50;
    // Strobe high and low times in ns, and cycles derived by rounding up
    localparam int E_HIGH_NS    = 160;
    localparam int E_LOW_NS     = 120;
    localparam int E_HIGH_CYC   = (E_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int E_LOW_CYC    = (E_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W        = 8;

    localparam int AC_W         = 7;
    localparam int TEXT_DEPTH   = 128;
    localparam int GLYPH_DEPTH  = 64;
    localparam int SEG_DEPTH    = 16;
    localparam logic [6:0] TEXT_MASK  = 7'h7F;
    localparam logic [6:0] GLYPH_MASK = 7'h3F;
    localparam logic [6:0] SEG_MASK   = 7'h0F;
    localparam logic [7:0] BLANK_CHAR = 8'h20;
    localparam logic [7:0] BUS_IDLE   = 8'hFF;

    // Bit positions inside instruction and status bytes
    localparam int BUSY_BIT     = 7;
    localparam int FS_DL_BIT    = 4;
    localparam int FS_RE_BIT    = 2;
    localparam int ENTRY_ID_BIT = 1;
    localparam int SHIFT_SC_BIT = 3;
    localparam int SHIFT_RL_BIT = 2;
    localparam int DISP_D_BIT   = 2;

    // Host start-up sequence
    localparam int INIT_REPEAT  = 3;
    localparam int INIT_STEPS   = 6;
    localparam logic [7:0] INIT_FUNC  = 8'h38;
    localparam logic [7:0] INIT_CLEAR = 8'h01;
    localparam logic [7:0] INIT_ENTRY = 8'h06;
    localparam logic [7:0] INIT_DISP  = 8'h0C;
    localparam logic [7:0] GLYPH_ADDR_CMD = 8'h40;
    localparam int GLYPH_BYTES  = 64;

    typedef enum logic [1:0] {RAM_TEXT = 2'b00, RAM_GLYPH = 2'b01, RAM_SEG = 2'b11} clh_ram_t;
    typedef enum logic [3:0] {
        I_NONE, I_CLEAR, I_HOME, I_ENTRY, I_DISP, I_SHIFT, I_FUNC, I_CGADDR, I_DDADDR
    } clh_instr_t;

    function automatic clh_instr_t clh_decode(input logic [7:0] b);
        if (b[7])      return I_DDADDR;
        else if (b[6]) return I_CGADDR;
        else if (b[5]) return I_FUNC;
        else if (b[4]) return I_SHIFT;
        else if (b[3]) return I_DISP;
        else if (b[2]) return I_ENTRY;
        else if (b[1]) return I_HOME;
        else if (b[0]) return I_CLEAR;
        else           return I_NONE;
    endfunction : clh_decode

    function automatic logic [6:0] clh_amask(input clh_ram_t s);
        unique case (s)
            RAM_TEXT:  return TEXT_MASK;
            RAM_GLYPH: return GLYPH_MASK;
            default:   return SEG_MASK;
        endcase
    endfunction : clh_amask

    function automatic logic [6:0] clh_step(input logic [6:0] a, input logic up, input logic [6:0] m);
        return (up ? a + 7'h01 : a - 7'h01) & m;
    endfunction : clh_step
endpackage : clh_pkg

// ===== clh_bus_if.sv
/*
 * Parallel instruction/data bus between host and display controller.
 * Each end drives the data lines with its own enable; the resolved level
 * floats high when nobody drives.
 */
`timescale 1ns/1ps
interface clh_bus_if;
    import clh_pkg::*;
    logic       e;
    logic       reg_select_line;
    logic       rw;
    logic [7:0] db_h;
    logic       db_h_oe;
    logic [7:0] db_d;
    logic       db_d_oe;
    logic [7:0] db;

    assign db = db_h_oe ? db_h : (db_d_oe ? db_d : BUS_IDLE);

    modport host (output e, reg_select_line, rw, db_h, db_h_oe, input db);
    modport dev  (input e, reg_select_line, rw, db, output db_d, db_d_oe);
endinterface : clh_bus_if

// ===== clh_dev.sv
/*
 * Controller end of the host port: status read, RAM data transfers, address
 * counter, read prefetch register, busy timing and 4-bit nibble pairing.
 * Assumes the host pins are asynchronous to clock_in and obey the busy flag.
 */
// Overview of operation
// - Status read returns busy_flag and address_counter
// - busy_flag high while previous instruction executes
// - Host waits for busy_flag low before transfers; the host skips this for status reads and the three start-up function sets
// - Data write stores one byte in RAM
// - Last address-set instruction selects target RAM
// - Address counter steps after each write
// - Data read returns one byte from RAM
// - First read without address set invalid
// - Cursor shift reloads output register like address
// - Address counter steps after each read
// - Shift after glyph/segment read not guaranteed
// - Read after write returns previously latched data
// - Host start-up: 38H thrice, 01H, 06H, 0CH
// - Glyph load: 40H then 64 polled writes
// - bus_width_bit selects 8-bit or 4-bit transfers
`timescale 1ns/1ps
module clh_dev
    import clh_pkg::*;
#(
    parameter int   EXEC_CYC   = 40,
    parameter int   CLEAR_CYC  = 100,
    parameter logic RESET_WIDE = 1'b1
)(
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    clh_bus_if.dev          bus,
    input  wire logic [6:0] disp_addr_in,
    output logic      [7:0] disp_data_out,
    output logic            busy_out,
    output logic            wide_bus_out,
    output logic            display_on_out,
    output logic      [6:0] disp_shift_out
);
    logic [10:0]      pin_s1;
    logic [10:0]      pin_s2;
    logic             e_s3;
    logic             e_p, rs_p, rw_p, e_rise, e_fall;
    logic [7:0]       db_p;

    logic [7:0]       display_text_ram [TEXT_DEPTH];
    logic [7:0]       user_glyph_ram   [GLYPH_DEPTH];
    logic [7:0]       segment_icon_ram [SEG_DEPTH];

    logic [AC_W-1:0]  address_counter, next_ac;
    clh_ram_t         sel, next_sel;
    logic [7:0]       odr, next_odr, pf, dout, next_dout, rd_val, cur;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic             busy_flag, next_busy, bus_width_bit, next_wide, re_bit, next_re, incr, next_incr;
    logic             disp_on, next_disp_on, phase, next_phase, doe, next_doe, wr_en, clr_en, ld_odr;
    logic [6:0]       shift, next_shift;
    logic [3:0]       hi_nib, next_hi;

    assign {e_p, rs_p, rw_p, db_p} = pin_s2;
    assign e_rise = e_p & ~e_s3;
    assign e_fall = ~e_p & e_s3;
    assign bus.db_d    = dout;
    assign bus.db_d_oe = doe;

    // Pins pass two flip-flops before any logic reads them
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pin_s1 <= 11'h000;
            pin_s2 <= 11'h000;
            e_s3   <= 1'b0;
        end
        else
        begin
            pin_s1 <= {bus.e, bus.reg_select_line, bus.rw, bus.db};
            pin_s2 <= pin_s1;
            e_s3   <= pin_s2[10];
        end
    end

    always_comb
    begin
        next_ac      = address_counter;
        next_sel     = sel;
        next_wide    = bus_width_bit;
        next_re      = re_bit;
        next_incr    = incr;
        next_disp_on = disp_on;
        next_shift   = shift;
        next_phase   = phase;
        next_hi      = hi_nib;
        next_dout    = dout;
        next_doe     = doe;
        wr_en        = 1'b0;
        clr_en       = 1'b0;
        ld_odr       = 1'b0;
        cur          = bus_width_bit ? db_p : {hi_nib, db_p[7:4]};
        next_cnt     = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
        rd_val       = rs_p ? odr : {busy_flag, address_counter};
        if (e_rise && rw_p)
        begin
            next_doe = 1'b1;
            if (bus_width_bit)
                next_dout = rd_val;
            else
                next_dout = phase ? {rd_val[3:0], 4'h0} : {rd_val[7:4], 4'h0};
        end
        if (e_fall)
        begin
            next_doe = 1'b0;
            if (!bus_width_bit)
            begin
                next_phase = ~phase;
                next_hi    = db_p[7:4];
            end
            // Writes while busy are dropped; the host is expected to poll
            if ((bus_width_bit || phase) && !busy_flag && !rw_p && !rs_p)
            begin
                next_cnt = CNT_W'(EXEC_CYC);
                unique case (clh_decode(cur))
                    I_CLEAR:
                    begin
                        clr_en    = 1'b1;
                        next_ac   = '0;
                        next_sel  = RAM_TEXT;
                        next_incr = 1'b1;
                        next_cnt  = CNT_W'(CLEAR_CYC);
                    end
                    I_HOME:
                    begin
                        next_ac    = '0;
                        next_shift = '0;
                    end
                    I_ENTRY: next_incr = cur[ENTRY_ID_BIT];
                    I_DISP:  next_disp_on = cur[DISP_D_BIT];
                    I_SHIFT:
                    begin
                        if (cur[SHIFT_SC_BIT])
                            next_shift = cur[SHIFT_RL_BIT] ? shift + 7'h01 : shift - 7'h01;
                        else
                        begin
                            next_ac = clh_step(address_counter, cur[SHIFT_RL_BIT], clh_amask(sel));
                            ld_odr = (sel == RAM_TEXT);
                        end
                    end
                    I_FUNC:
                    begin
                        next_wide = cur[FS_DL_BIT];
                        next_re   = cur[FS_RE_BIT];
                    end
                    I_CGADDR:
                    begin
                        next_sel = re_bit ? RAM_SEG : RAM_GLYPH;
                        next_ac  = cur[6:0] & clh_amask(next_sel);
                        ld_odr   = 1'b1;
                    end
                    I_DDADDR:
                    begin
                        if (!re_bit)
                        begin
                            next_sel = RAM_TEXT;
                            next_ac  = cur[6:0];
                            ld_odr   = 1'b1;
                        end
                    end
                    default: next_cnt = CNT_W'(EXEC_CYC);
                endcase
            end
            else if ((bus_width_bit || phase) && !busy_flag && rs_p)
            begin
                next_cnt = CNT_W'(EXEC_CYC);
                wr_en = !rw_p;
                next_ac = clh_step(address_counter, incr, clh_amask(sel));
                ld_odr = rw_p;
            end
        end
        next_busy = (next_cnt != '0);
    end

    // Prefetch from the RAM that the next address will point into
    always_comb
    begin
        unique case (next_sel)
            RAM_TEXT:  pf = display_text_ram[next_ac];
            RAM_GLYPH: pf = user_glyph_ram[next_ac[5:0]];
            default:   pf = segment_icon_ram[next_ac[3:0]];
        endcase
    end
    assign next_odr = ld_odr ? pf : odr;

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            address_counter <= '0;
            sel             <= RAM_TEXT;
            odr             <= '0;
            cnt             <= '0;
            busy_flag       <= 1'b0;
            bus_width_bit   <= RESET_WIDE;
            re_bit          <= 1'b0;
            incr            <= 1'b1;
            disp_on         <= 1'b0;
            shift           <= '0;
            phase           <= 1'b0;
            hi_nib          <= '0;
            dout            <= '0;
            doe             <= 1'b0;
            busy_out        <= 1'b0;
            wide_bus_out    <= RESET_WIDE;
            display_on_out  <= 1'b0;
            disp_shift_out  <= '0;
        end
        else
        begin
            address_counter <= next_ac;
            sel             <= next_sel;
            odr             <= next_odr;
            cnt             <= next_cnt;
            busy_flag       <= next_busy;
            bus_width_bit   <= next_wide;
            re_bit          <= next_re;
            incr            <= next_incr;
            disp_on         <= next_disp_on;
            shift           <= next_shift;
            phase           <= next_phase;
            hi_nib          <= next_hi;
            dout            <= next_dout;
            doe             <= next_doe;
            busy_out        <= next_busy;
            wide_bus_out    <= next_wide;
            display_on_out  <= next_disp_on;
            disp_shift_out  <= next_shift;
        end
    end

    // RAM contents carry no reset; clear-display fills the text RAM with blanks
    always_ff @(posedge clock_in)
    begin
        if (clr_en)
        begin
            for (int i = 0; i < TEXT_DEPTH; i++)
                display_text_ram[i] <= BLANK_CHAR;
        end
        else if (wr_en)
        begin
            unique case (sel)
                RAM_TEXT:  display_text_ram[address_counter] <= cur;
                RAM_GLYPH: user_glyph_ram[address_counter[5:0]] <= cur;
                default:   segment_icon_ram[address_counter[3:0]] <= cur;
            endcase
        end
        disp_data_out <= display_text_ram[disp_addr_in];
    end
endmodule : clh_dev

// ===== clh_host.sv
/*
 * Host end of the display port: turns user commands into strobed bus
 * transfers, polls the busy flag first except for status reads and the three blind function sets, splits bytes in 4-bit mode and
 * runs the start-up sequence. Assumes the controller answers within E high.
 */
`timescale 1ns/1ps
module clh_host
    import clh_pkg::*;
#(
    parameter int   INIT_GAP   = 64,
    parameter logic RESET_WIDE = 1'b1
)(
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    clh_bus_if.host         bus,
    input  wire logic       cmd_valid_in,
    input  wire logic       cmd_rs_in,
    input  wire logic       cmd_rw_in,
    input  wire logic [7:0] cmd_data_in,
    output logic            cmd_ready_out,
    output logic            rsp_valid_out,
    output logic      [7:0] rsp_data_out,
    input  wire logic       init_start_in,
    output logic            init_busy_out
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000, H_SETUP = 3'b001, H_HIGH = 3'b011, H_LOW = 3'b010, H_GAP = 3'b110
    } clh_hst_t;

    clh_hst_t         st, next_st;
    logic [7:0]       db_s1, db_s2;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic             e, next_e, rs, next_rs, rw, next_rw, oe, next_oe;
    logic [7:0]       dh, next_dh, op, next_op, rd, next_rd;
    logic             op_rs, next_op_rs, op_rw, next_op_rw;
    logic             polling, next_polling, nib, next_nib, wide, next_wide;
    logic             init_act, next_init_act;
    logic [2:0]       step, next_step;
    logic             next_ready, next_rsp_v;
    logic [7:0]       next_rsp_d, init_code;

    assign bus.e               = e;
    assign bus.reg_select_line = rs;
    assign bus.rw              = rw;
    assign bus.db_h            = dh;
    assign bus.db_h_oe         = oe;

    always_comb
    begin
        unique case (step)
            3'h0, 3'h1, 3'h2: init_code = INIT_FUNC;
            3'h3:             init_code = INIT_CLEAR;
            3'h4:             init_code = INIT_ENTRY;
            default:          init_code = INIT_DISP;
        endcase
    end

    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_e = e;
        next_rs = rs;
        next_rw = rw;
        next_oe = oe;
        next_dh = dh;
        next_op = op;
        next_rd = rd;
        next_op_rs = op_rs;
        next_op_rw = op_rw;
        next_polling = polling;
        next_nib = nib;
        next_wide = wide;
        next_init_act = init_act;
        next_step = step;
        next_rsp_v = 1'b0;
        next_rsp_d = rsp_data_out;
        unique case (st)
            H_IDLE:
            begin
                if (init_act || init_start_in || (cmd_valid_in && cmd_ready_out))
                begin
                    next_init_act = 1'b1;
                    next_op = init_code;
                    next_op_rs = 1'b0;
                    next_op_rw = 1'b0;
                    // poll before every transfer except the blind function sets and status reads
                    next_polling = (step >= 3'(INIT_REPEAT));
                    if (!init_act && !init_start_in)
                    begin
                        next_init_act = 1'b0;
                        next_op = cmd_data_in;
                        next_op_rs = cmd_rs_in;
                        next_op_rw = cmd_rw_in;
                        next_polling = cmd_rs_in || !cmd_rw_in;
                    end
                    next_rs = next_polling ? 1'b0 : next_op_rs;
                    next_rw = next_polling ? 1'b1 : next_op_rw;
                    next_oe = !next_rw;
                    next_dh = next_op;
                    next_nib = 1'b0;
                    next_st = H_SETUP;
                end
            end
            H_SETUP:
            begin
                next_e = 1'b1;
                next_cnt = CNT_W'(E_HIGH_CYC - 1);
                next_st = H_HIGH;
            end
            H_HIGH:
            begin
                next_cnt = cnt - CNT_W'(1);
                if (cnt == '0)
                begin
                    if (wide)
                        next_rd = db_s2;
                    else if (!nib)
                        next_rd = {db_s2[7:4], rd[3:0]};
                    else
                        next_rd = {rd[7:4], db_s2[7:4]};
                    next_e = 1'b0;
                    next_cnt = CNT_W'(E_LOW_CYC - 1);
                    next_st = H_LOW;
                end
            end
            H_LOW:
            begin
                next_cnt = cnt - CNT_W'(1);
                if (cnt == '0)
                begin
                    next_st = H_SETUP;
                    if (!wide && !nib)
                    begin
                        next_nib = 1'b1;
                        next_dh = {dh[3:0], 4'h0};
                    end
                    else if (polling)
                    begin
                        next_nib = 1'b0;
                        if (!rd[BUSY_BIT])
                        begin
                            next_polling = 1'b0;
                            next_rs = op_rs;
                            next_rw = op_rw;
                            next_oe = !op_rw;
                            next_dh = op;
                        end
                    end
                    else
                    begin
                        next_oe = 1'b0;
                        next_rsp_v = rw;
                        next_rsp_d = next_rd;
                        if (!rs && !rw && clh_decode(op) == I_FUNC)
                            next_wide = op[FS_DL_BIT];
                        next_st = H_IDLE;
                        if (init_act)
                        begin
                            next_step = step + 3'h1;
                            next_init_act = (step != 3'(INIT_STEPS - 1));
                            if (step < 3'(INIT_REPEAT))
                            begin
                                next_cnt = CNT_W'(INIT_GAP - 1);
                                next_st = H_GAP;
                            end
                        end
                        if (!next_init_act)
                            next_step = '0;
                    end
                end
            end
            default:
            begin
                next_cnt = cnt - CNT_W'(1);
                if (cnt == '0)
                    next_st = H_IDLE;
            end
        endcase
        next_ready = (next_st == H_IDLE) && !next_init_act;
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st <= H_IDLE;
            cnt <= '0;
            e <= 1'b0;
            rs <= 1'b0;
            rw <= 1'b1;
            oe <= 1'b0;
            dh <= '0;
            op <= '0;
            rd <= '0;
            op_rs <= 1'b0;
            op_rw <= 1'b0;
            polling <= 1'b0;
            nib <= 1'b0;
            wide <= RESET_WIDE;
            init_act <= 1'b0;
            step <= '0;
            db_s1 <= '0;
            db_s2 <= '0;
            cmd_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_data_out <= '0;
            init_busy_out <= 1'b0;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            e <= next_e;
            rs <= next_rs;
            rw <= next_rw;
            oe <= next_oe;
            dh <= next_dh;
            op <= next_op;
            rd <= next_rd;
            op_rs <= next_op_rs;
            op_rw <= next_op_rw;
            polling <= next_polling;
            nib <= next_nib;
            wide <= next_wide;
            init_act <= next_init_act;
            step <= next_step;
            db_s1 <= bus.db;
            db_s2 <= db_s1;
            cmd_ready_out <= next_ready;
            rsp_valid_out <= next_rsp_v;
            rsp_data_out <= next_rsp_d;
            init_busy_out <= next_init_act;
        end
    end
endmodule : clh_host

// ===== clh_props.sv
/* Checker for the host port link between host and controller.
   Assumes one clock domain and the interface signals as plain inputs. */
`timescale 1ns/1ps
module clh_props (
    input wire logic       clock_in,
    input wire logic       nrst_in,
    input wire logic       e,
    input wire logic       reg_select_line,
    input wire logic       rw,
    input wire logic [7:0] db_h,
    input wire logic       db_h_oe,
    input wire logic       db_d_oe
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    property p_one_drv; !(db_h_oe && db_d_oe); endproperty
    a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
    property p_dev_rd; db_d_oe |-> rw; endproperty
    a_dev_rd: assert property (p_dev_rd) else $error("device drives outside a read");
    property p_host_wr; db_h_oe |-> !rw && reg_select_line || !rw; endproperty
    a_host_wr: assert property (p_host_wr) else $error("host drives during a read");
    property p_e_high; $rose(e) |=> e[*7]; endproperty
    a_e_high: assert property (p_e_high) else $error("strobe high too short");
    property p_e_low; $fell(e) |=> (!e)[*5]; endproperty
    a_e_low: assert property (p_e_low) else $error("strobe low too short");
    property p_hold; e && $past(e) |-> $stable(reg_select_line) && $stable(rw) && ($stable(db_h) || !db_h_oe); endproperty
    a_hold: assert property (p_hold) else $error("lines move while strobe high");
    property p_answer; $rose(e) && rw |-> ##[2:4] db_d_oe; endproperty
    a_answer: assert property (p_answer) else $error("no read answer");
    property p_after; $fell(e) |=> ($stable(reg_select_line) && $stable(rw))[*5]; endproperty
    a_after: assert property (p_after) else $error("lines move too soon after strobe");
endmodule : clh_props

// ===== clh_tb.sv
/* Self-checking bench: host and controller joined by the bus interface.
   Assumes the controller's default busy times. */
`timescale 1ns/1ps
module clh_tb;
    logic       clock_in = 1'b0;
    logic       nrst_in = 1'b0;
    logic       cmd_valid_in = 1'b0, cmd_rs_in = 1'b0, cmd_rw_in = 1'b0, init_start_in = 1'b0;
    logic [7:0] cmd_data_in = 8'h00, rsp_data_out, disp_data_out, rd;
    logic [6:0] disp_addr_in = 7'h00, disp_shift_out;
    logic       cmd_ready_out, rsp_valid_out, init_busy_out, busy_out, wide_bus_out, display_on_out;
    logic [3:0] nib_a, nib_b;
    int         errors = 0, num_checks = 0, strobes = 0, s;
    clh_bus_if bus ();
    clh_host i_clh_host (.clock_in(clock_in), .nrst_in(nrst_in), .bus(bus), .cmd_valid_in(cmd_valid_in),
        .cmd_rs_in(cmd_rs_in), .cmd_rw_in(cmd_rw_in), .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .init_start_in(init_start_in),
        .init_busy_out(init_busy_out));
    clh_dev i_clh_dev (.clock_in(clock_in), .nrst_in(nrst_in), .bus(bus), .disp_addr_in(disp_addr_in),
        .disp_data_out(disp_data_out), .busy_out(busy_out), .wide_bus_out(wide_bus_out),
        .display_on_out(display_on_out), .disp_shift_out(disp_shift_out));
    clh_props i_clh_props (.clock_in(clock_in), .nrst_in(nrst_in), .e(bus.e), .reg_select_line(bus.reg_select_line),
        .rw(bus.rw), .db_h(bus.db_h), .db_h_oe(bus.db_h_oe), .db_d_oe(bus.db_d_oe));
    always #10 clock_in = ~clock_in;
    // Host-driven nibbles only, so polls do not disturb the record
    always @(negedge bus.e)
    begin
        strobes++;
        if (bus.db_h_oe === 1'b1)
        begin
            nib_b = nib_a;
            nib_a = bus.db[7:4];
        end
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic step(inout int n);
        @(posedge clock_in);
        n++;
        if (n > 6000)
        begin
            errors++;
            give_verdict();
        end
    endtask : step
    task automatic xfer(input logic rs, input logic rwb, input logic [7:0] d);
        int n;
        n = 0;
        do
            step(n);
        while (cmd_ready_out !== 1'b1);
        cmd_valid_in <= 1'b1;
        cmd_rs_in <= rs;
        cmd_rw_in <= rwb;
        cmd_data_in <= d;
        step(n);
        cmd_valid_in <= 1'b0;
        while (rwb && rsp_valid_out !== 1'b1)
            step(n);
        rd = rsp_data_out;
    endtask : xfer
    // Status reads until the busy flag drops; rd then holds the counter
    task automatic settle;
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, 1'b1, 8'h00);
            step(n);
        end
        while (rd[7] !== 1'b0);
    endtask : settle
    task automatic dchk(input logic [6:0] a, input logic [7:0] exp);
        disp_addr_in <= a;
        repeat (2) @(posedge clock_in);
        check8(disp_data_out, exp);
    endtask : dchk
    initial
    begin
        repeat (8) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        init_start_in <= 1'b1;
        @(posedge clock_in);
        init_start_in <= 1'b0;
        s = 0;
        do
            step(s);
        while (init_busy_out !== 1'b0);
        check8({6'h00, wide_bus_out, display_on_out}, 8'h03);
        xfer(1'b0, 1'b1, 8'h00);
        check8(rd, 8'h80);
        settle();
        check8(rd, 8'h00);
        $display("start-up test done");
        xfer(1'b0, 1'b0, 8'h85);
        xfer(1'b1, 1'b0, 8'hA1);
        xfer(1'b1, 1'b0, 8'hB2);
        settle();
        check8(rd, 8'h07);
        dchk(7'h06, 8'hB2);
        xfer(1'b0, 1'b0, 8'h85);
        xfer(1'b1, 1'b1, 8'h00);
        check8(rd, 8'hA1);
        xfer(1'b1, 1'b1, 8'h00);
        check8(rd, 8'hB2);
        settle();
        check8(rd, 8'h07);
        xfer(1'b1, 1'b0, 8'hD4);
        xfer(1'b1, 1'b1, 8'h00);
        check8(rd, 8'h20);
        xfer(1'b0, 1'b0, 8'h84);
        xfer(1'b0, 1'b0, 8'h14);
        xfer(1'b1, 1'b1, 8'h00);
        check8(rd, 8'hA1);
        xfer(1'b0, 1'b0, 8'h42);
        xfer(1'b1, 1'b0, 8'h5A);
        xfer(1'b0, 1'b0, 8'h42);
        xfer(1'b1, 1'b1, 8'h00);
        check8(rd, 8'h5A);
        dchk(7'h02, 8'h20);
        xfer(1'b0, 1'b0, 8'h04);
        xfer(1'b0, 1'b0, 8'h90);
        xfer(1'b1, 1'b0, 8'h11);
        settle();
        check8(rd, 8'h0F);
        $display("data test done");
        xfer(1'b0, 1'b0, 8'h28);
        xfer(1'b0, 1'b0, 8'hA0);
        xfer(1'b1, 1'b0, 8'h7E);
        settle();
        check8({nib_b, nib_a}, 8'h7E);
        s = strobes;
        xfer(1'b0, 1'b1, 8'h00);
        check8(8'(strobes - s), 8'h02);
        dchk(7'h20, 8'h7E);
        xfer(1'b0, 1'b0, 8'h38);
        settle();
        check8({7'h00, wide_bus_out}, 8'h01);
        xfer(1'b0, 1'b0, 8'h42);
        xfer(1'b1, 1'b1, 8'h00);
        check8(rd, 8'h5A);
        xfer(1'b0, 1'b0, 8'h1C);
        settle();
        check8({1'b0, disp_shift_out}, 8'h01);
        check8({7'h00, busy_out}, 8'h00);
        $display("nibble test done");
        give_verdict();
    end
endmodule : clh_tb
